// ==== hdl/eecu_top.sv ====
// Purpose: enclave entry validation and context rebuild behind AXI4-Lite
// Assumes: software loads the context words, then writes start
// Notes:   context is frozen while a check runs; one entry at a time
`include "eecu_cfg.svh"

module eecu_top
#(
  parameter int VA_W = 48
)
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    awvalid,
  output      logic                    awready,
  input  wire logic [`EECU_ADDR_W-1:0] awaddr,
  input  wire logic                    wvalid,
  output      logic                    wready,
  input  wire eecu_pkg::eecu_word_type wdata,
  input  wire logic [3:0]              wstrb,
  output      logic                    bvalid,
  input  wire logic                    bready,
  output      logic [1:0]              bresp,
  input  wire logic                    arvalid,
  output      logic                    arready,
  input  wire logic [`EECU_ADDR_W-1:0] araddr,
  output      logic                    rvalid,
  input  wire logic                    rready,
  output      eecu_pkg::eecu_word_type rdata,
  output      logic [1:0]              rresp
);
  import eecu_pkg::*;

  eecu_word_type               ctx [`EECU_CTX_N];
  eecu_word_type               res [`EECU_RES_N];
  eecu_word_type               nres [`EECU_RES_N];
  eecu_state_type              state;
  eecu_state_type              next_state;
  eecu_stat_type               stat;
  eecu_stat_type               next_stat;
  logic [4:0]                  cause;
  logic                        aw_hold;
  logic                        w_hold;
  logic [`EECU_ADDR_W-1:0]     aw_addr_q;
  eecu_word_type               w_data_q;
  logic [3:0]                  w_strb_q;

  // Write side holds each channel until both have arrived
  wire       do_write = aw_hold & w_hold & ~bvalid;
  wire [7:0] wr_idx   = aw_addr_q[`EECU_ADDR_W-1:2];
  wire [7:0] wr_ci    = wr_idx - `EECU_CTX_IDX;
  wire       wr_cmd   = wr_idx == `EECU_CMD_IDX;
  wire       wr_ctx   = (wr_idx >= `EECU_CTX_IDX) &
                        (wr_ci < 8'(`EECU_CTX_N));
  wire       idle     = state == ST_IDLE;
  wire       start_cmd = do_write & wr_cmd & w_strb_q[0] & idle &
                         w_data_q[`EECU_CMD_START];
  wire       exit_cmd  = do_write & wr_cmd & w_strb_q[0] & idle &
                         w_data_q[`EECU_CMD_EXIT] & stat.encl;

  assign awready = ~aw_hold;
  assign wready  = ~w_hold;
  assign arready = ~rvalid;

  // Field views of the context words
  eecu_mode_type m;
  assign m = eecu_mode_type'(ctx[`EECU_C_MODE]);
  wire [63:0] tcs_a  = {ctx[`EECU_C_TCS+1], ctx[`EECU_C_TCS]};
  wire [63:0] pm_a   = {ctx[`EECU_C_PMADDR+1], ctx[`EECU_C_PMADDR]};
  wire [63:0] async_exit_pointer    = {ctx[`EECU_C_AEP+1], ctx[`EECU_C_AEP]};
  wire [63:0] base   = {ctx[`EECU_C_BASE+1], ctx[`EECU_C_BASE]};
  wire [63:0] entry  = {ctx[`EECU_C_ENTRY+1], ctx[`EECU_C_ENTRY]};
  wire [63:0] save_o = {ctx[`EECU_C_SAVE+1], ctx[`EECU_C_SAVE]};
  wire [63:0] fs_o   = {ctx[`EECU_C_FSOFS+1], ctx[`EECU_C_FSOFS]};
  wire [63:0] gs_o   = {ctx[`EECU_C_GSOFS+1], ctx[`EECU_C_GSOFS]};
  wire [63:0] flags  = {ctx[`EECU_C_FLAGS+1], ctx[`EECU_C_FLAGS]};
  wire [31:0] ds_lim = ctx[`EECU_C_DSLIM];
  wire [31:0] xstate_feature_mask   = ctx[`EECU_C_XSTATE_FEATURE_MASK];
  wire [31:0] xcr    = ctx[`EECU_C_XCR];
  wire        opt_in = flags[`EECU_FLAG_OPTIN];

  wire mode64 = m.long_active & m.cs_long;

  // Canonical when the top implemented bit and all bits above it agree
  function automatic logic canon(input logic [63:0] a);
    return (a[63:VA_W-1] == '0) | (a[63:VA_W-1] == '1);
  endfunction

  // Entry target and proposed segment bases
  wire [63:0] target  = base + entry;
  wire [63:0] fs_base = base + fs_o;
  wire [63:0] gs_base = base + gs_o;
  wire [32:0] fs_end  = {1'b0, fs_base[31:0]} + {1'b0, ctx[`EECU_C_FSLIM]};
  wire [32:0] gs_end  = {1'b0, gs_base[31:0]} + {1'b0, ctx[`EECU_C_GSLIM]};
  // A wrapping segment is only legal when the data segment spans 4 GB
  wire fs_bad32 = fs_end[32] ? (ds_lim != `EECU_DS_FULL) :
                               (fs_end[31:0] > ds_lim);
  wire gs_bad32 = gs_end[32] ? (ds_lim != `EECU_DS_FULL) :
                               (gs_end[31:0] > ds_lim);
  wire xs_bad   = m.os_xstate_enable ? ((xstate_feature_mask & xcr) != xstate_feature_mask) :
                  (m.xsave_avail & (xstate_feature_mask != `EECU_XSTATE_FEATURE_MASK_LEGACY));

  // Checks in evaluation order; the lowest set bit is reported
  logic [`EECU_CHK_N-1:0] chk;
  assign chk[0]  = ~mode64 & (~m.ds_usable | (m.ds_type != `EECU_DS_TYPE_OK));
  assign chk[1]  = ~mode64 & (m.cs_base_nz | m.ds_base_nz);
  assign chk[2]  = ~mode64 & m.es_usable & m.es_base_nz;
  assign chk[3]  = ~mode64 & m.ss_usable & m.ss_base_nz;
  assign chk[4]  = ~mode64 & m.ss_usable & ~m.ss_b;
  assign chk[5]  = (tcs_a & `EECU_PAGE_MASK) != '0;
  assign chk[6]  = ~m.in_page_cache;
  assign chk[7]  = mode64 & ~canon(async_exit_pointer);
  assign chk[8]  = m.tcs_busy;
  assign chk[9]  = ~m.pm_valid;
  assign chk[10] = m.pm_blocked;
  assign chk[11] = (pm_a != tcs_a) |
                   (ctx[`EECU_C_PMTYPE][7:0] != `EECU_THREAD_CTL_PAGE_TYPE);
  assign chk[12] = m.pm_pending | m.pm_modified;
  assign chk[13] = (save_o & `EECU_PAGE_MASK) != '0;
  assign chk[14] = ((fs_o | gs_o) & `EECU_PAGE_MASK) != '0;
  assign chk[15] = (flags & `EECU_FLAGS_MBZ) != '0;
  assign chk[16] = ~m.initialized;
  assign chk[17] = mode64 != m.wide_mode_attr;
  // Floating point save support is required before the mask test
  assign chk[18] = ~m.os_fp_save_enable;
  assign chk[19] = xs_bad;
  assign chk[20] = ~opt_in & (flags[`EECU_FLAG_NOTIFY] != m.notify_attr);
  assign chk[21] = mode64 ? ~canon(target) :
                            (target[31:0] > ctx[`EECU_C_CSLIM]);
  // fs and gs canonical in wide mode, inside data segment in narrow mode
  assign chk[22] = mode64 ? (~canon(fs_base) | ~canon(gs_base)) :
                            (fs_bad32 | gs_bad32);

  function automatic logic [4:0] first_fault(input logic [22:0] v);
    logic [4:0] r;
    r = `EECU_NO_FAULT;
    for (int i = `EECU_CHK_N - 1; i >= 0; i--)
      if (v[i])
        r = 5'(i);
    return r;
  endfunction

  wire found = cause != `EECU_NO_FAULT;
  wire is_pf = found & |(`EECU_PF_MASK & (23'h1 << cause));
  wire commit = state == ST_COMMIT;

  assign nres[0]  = target[31:0];
  assign nres[1]  = target[63:32];
  assign nres[2]  = tcs_a[31:0];
  assign nres[3]  = tcs_a[63:32];
  assign nres[4]  = ctx[`EECU_C_NEXTIP];
  assign nres[5]  = ctx[`EECU_C_NEXTIP+1];
  assign nres[6]  = ctx[`EECU_C_CURRENT_SAVE_FRAME_INDEX];
  assign nres[7]  = async_exit_pointer[31:0];
  assign nres[8]  = async_exit_pointer[63:32];
  // rebuilt segments; limits only in narrow mode
  assign nres[9]  = fs_base[31:0];
  assign nres[10] = mode64 ? fs_base[63:32] : `EECU_WORD_RST;
  assign nres[11] = gs_base[31:0];
  assign nres[12] = mode64 ? gs_base[63:32] : `EECU_WORD_RST;
  assign nres[13] = mode64 ? `EECU_WORD_RST : ctx[`EECU_C_FSLIM];
  assign nres[14] = mode64 ? `EECU_WORD_RST : ctx[`EECU_C_GSLIM];
  assign nres[15] = xcr;
  assign nres[16] = m.os_xstate_enable ? xstate_feature_mask : xcr;
  // stack and frame pointers into save frame
  assign nres[17] = ctx[`EECU_C_SP];
  assign nres[18] = ctx[`EECU_C_SP+1];
  assign nres[19] = ctx[`EECU_C_FP];
  assign nres[20] = ctx[`EECU_C_FP+1];
  assign nres[21] = ctx[`EECU_C_OLDFS];
  assign nres[22] = ctx[`EECU_C_OLDGS];
  // global status bits 60 and 63
  assign nres[23] = opt_in ? `EECU_WORD_RST : `EECU_PERF_FLAGS;

  // Context words: byte-lane writes, refused while a check runs
  for (genvar g = 0; g < `EECU_CTX_N; g++)
  begin : g_ctx
    wire hit = do_write & wr_ctx & idle & (wr_ci[5:0] == 6'(g));
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        ctx[g] <= `EECU_WORD_RST;
      else if (hit)
        for (int b = 0; b < 4; b++)
          if (w_strb_q[b])
            ctx[g][8*b +: 8] <= w_data_q[8*b +: 8];
    end
  end

  // Result words: fault address only on a page fault, rest on success
  for (genvar g = 0; g < `EECU_RES_N; g++)
  begin : g_res
    wire upd = commit & ((g == 2 || g == 3) ? is_pf : ~found);
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        res[g] <= `EECU_WORD_RST;
      else if (upd)
        res[g] <= nres[g];
    end
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (start_cmd) next_state = ST_CHECK;
      ST_CHECK:  next_state = ST_COMMIT;
      ST_COMMIT: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  // Status update on start, commit and exit
  always_comb
  begin
    next_stat = stat;
    if (start_cmd)
    begin
      next_stat.done = 1'b0;
      next_stat.gp   = 1'b0;
      next_stat.pf   = 1'b0;
    end
    if (exit_cmd)
    begin
      next_stat = '0;
      next_stat.done      = stat.done;
      next_stat.trap_flag = stat.tf_saved;
    end
    if (commit)
    begin
      next_stat.done = 1'b1;
      next_stat.gp   = found & ~is_pf;
      next_stat.pf   = is_pf;
      if (!found)
      begin
        next_stat.encl        = 1'b1;
        next_stat.tf_saved    = m.trap_flag;
        next_stat.trap_flag   = opt_in & m.trap_flag;
        next_stat.sstep       = opt_in;
        next_stat.bp_out_supp = 1'b1;
        next_stat.bp_in_supp  = ~opt_in;
        next_stat.perf_supp   = ~opt_in;
        next_stat.precise_event_sampling_supp   = ~opt_in;
        next_stat.demote      = ~opt_in;
        next_stat.xcr_loaded  = m.os_xstate_enable;
      end
    end
  end

  // Sequencer, fault capture and status flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_IDLE;
      stat  <= '0;
      cause <= `EECU_NO_FAULT;
    end
    else
    begin
      state <= next_state;
      stat  <= next_stat;
      if (state == ST_CHECK)
        cause <= first_fault(chk);
    end
  end

  // Write channels and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold   <= 1'b0;
      w_hold    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `EECU_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q  <= `EECU_WORD_RST;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      if (awvalid & awready)
      begin
        aw_hold   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid & wready)
      begin
        w_hold   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write)
      begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (wr_cmd | wr_ctx) ? `EECU_RESP_OKAY : `EECU_RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // Read decode; read-only status and results, holes answer SLVERR
  wire [7:0] rd_idx = araddr[`EECU_ADDR_W-1:2];
  wire [7:0] rd_ci  = rd_idx - `EECU_CTX_IDX;
  wire [7:0] rd_ri  = rd_idx - `EECU_RES_IDX;
  wire       rd_ctx = (rd_idx >= `EECU_CTX_IDX) & (rd_ci < 8'(`EECU_CTX_N));
  wire       rd_res = (rd_idx >= `EECU_RES_IDX) & (rd_ri < 8'(`EECU_RES_N));
  wire       rd_st  = rd_idx == `EECU_STAT_IDX;
  wire       rd_cmd = rd_idx == `EECU_CMD_IDX;
  wire [31:0] st_word = {11'h000, cause, 2'h0, stat, ~idle};
  wire [31:0] rd_word = rd_ctx ? ctx[rd_ci[5:0]] :
                        rd_res ? res[rd_ri[4:0]] :
                        rd_st  ? st_word : `EECU_WORD_RST;
  wire        rd_ok   = rd_ctx | rd_res | rd_st | rd_cmd;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= `EECU_WORD_RST;
      rresp  <= `EECU_RESP_OKAY;
    end
    else if (arvalid & arready)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_ok ? `EECU_RESP_OKAY : `EECU_RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule

// ==== hdl/eecu_cfg.svh ====
// Purpose: offsets, field positions and reset values of the entry checker
// Assumes: byte address = 4 * word index on a 32-bit AXI4-Lite bus
// Notes:   64-bit values take two words, low word first
`ifndef EECU_CFG_SVH
`define EECU_CFG_SVH
`define EECU_ADDR_W 10
`define EECU_CMD_IDX 8'h00
`define EECU_CTX_IDX 8'h01
`define EECU_CTX_N 35
`define EECU_STAT_IDX 8'h3F
`define EECU_RES_IDX 8'h40
`define EECU_RES_N 24
`define EECU_CMD_START 0
`define EECU_CMD_EXIT 1
`define EECU_C_MODE 0
`define EECU_C_TCS 1
`define EECU_C_PMADDR 3
`define EECU_C_PMTYPE 5
`define EECU_C_AEP 6
`define EECU_C_BASE 8
`define EECU_C_ENTRY 10
`define EECU_C_SAVE 12
`define EECU_C_FSOFS 14
`define EECU_C_GSOFS 16
`define EECU_C_FLAGS 18
`define EECU_C_FSLIM 20
`define EECU_C_GSLIM 21
`define EECU_C_CSLIM 22
`define EECU_C_DSLIM 23
`define EECU_C_XSTATE_FEATURE_MASK 24
`define EECU_C_XCR 25
`define EECU_C_SP 26
`define EECU_C_FP 28
`define EECU_C_NEXTIP 30
`define EECU_C_CURRENT_SAVE_FRAME_INDEX 32
`define EECU_C_OLDFS 33
`define EECU_C_OLDGS 34
`define EECU_FLAG_OPTIN 0
`define EECU_FLAG_NOTIFY 1
`define EECU_WORD_RST 32'h0000_0000
`define EECU_PAGE_MASK 64'h0000_0000_0000_0FFF
`define EECU_FLAGS_MBZ 64'hFFFF_FFFF_FFFF_FFFC
`define EECU_XSTATE_FEATURE_MASK_LEGACY 32'h0000_0003
`define EECU_THREAD_CTL_PAGE_TYPE 8'h01
`define EECU_DS_TYPE_OK 3'h1
`define EECU_DS_FULL 32'hFFFF_FFFF
`define EECU_PERF_FLAGS 32'h9000_0000
`define EECU_CHK_N 23
`define EECU_PF_MASK 23'h001E40
`define EECU_NO_FAULT 5'h1F
`define EECU_RESP_OKAY 2'h0
`define EECU_RESP_SLVERR 2'h2
`endif

// ==== hdl/eecu_pkg.sv ====
// Purpose: types shared by the entry checker
// Assumes: mode word layout as loaded by software
// Notes:   structs are packed MSB first
package eecu_pkg;
  typedef logic [31:0] eecu_word_type;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'h1,
    ST_CHECK  = 3'h2,
    ST_COMMIT = 3'h4
  } eecu_state_type;

  typedef struct packed {
    logic [5:0] rsvd;
    logic       trap_flag;
    logic       ss_base_nz;
    logic       es_base_nz;
    logic       ds_base_nz;
    logic       cs_base_nz;
    logic       pm_modified;
    logic       pm_pending;
    logic       pm_blocked;
    logic       pm_valid;
    logic       in_page_cache;
    logic       notify_attr;
    logic       wide_mode_attr;
    logic       initialized;
    logic       tcs_busy;
    logic       xsave_avail;
    logic       os_fp_save_enable;
    logic       os_xstate_enable;
    logic [2:0] ds_type;
    logic       ss_b;
    logic       ss_usable;
    logic       es_usable;
    logic       ds_usable;
    logic       cs_long;
    logic       long_active;
  } eecu_mode_type;

  typedef struct packed {
    logic xcr_loaded;
    logic tf_saved;
    logic trap_flag;
    logic demote;
    logic precise_event_sampling_supp;
    logic perf_supp;
    logic bp_in_supp;
    logic bp_out_supp;
    logic sstep;
    logic encl;
    logic pf;
    logic gp;
    logic done;
  } eecu_stat_type;
endpackage

// ==== tb/eecu_top_sva.sv ====
// Purpose: bus protocol checks on the entry checker ports
// Assumes: one clock, sync active-low reset
// Notes:   bound in from the bench top; address and write data lines not needed
`include "eecu_cfg.svh"
module eecu_top_sva
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic                    wvalid,
  input wire logic                    wready,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic [1:0]              bresp,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic                    rvalid,
  input wire logic                    rready,
  input wire eecu_pkg::eecu_word_type rdata,
  input wire logic [1:0]              rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Write answer lands two edges after a joint handshake
  AST_WR_ANSWER: assert property (
    awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
    else $error("write answer not two edges after handshake");
  // A taken address blocks the next one until the write is done
  AST_AW_REFUSE: assert property (
    awvalid && awready |=> !awready)
    else $error("address accepted while one is held");
  // Response stands until the master takes it
  AST_B_HOLD: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_B_DROP: assert property (
    bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  // Read side: one answer at a time, one edge after the request
  AST_AR_READY: assert property (
    arready == !rvalid)
    else $error("read ready not inverse of read valid");
  AST_RD_ANSWER: assert property (
    arvalid && arready |=> rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed before taken");
  AST_R_DROP: assert property (
    rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  // Refused reads carry no stale data
  AST_SLVERR_ZERO: assert property (
    rvalid && rresp == `EECU_RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read returned data");
endmodule

// ==== tb/eecu_sw_model.sv ====
// Purpose: software side issuing register traffic to the entry checker
// Assumes: called from the bench, one transfer at a time
// Notes:   slow delays the answer ready by a few edges
module eecu_sw_model
(
  input  wire logic                    aclk,
  output      logic                    awvalid,
  input  wire logic                    awready,
  output      logic [9:0]              awaddr,
  output      logic                    wvalid,
  input  wire logic                    wready,
  output      eecu_pkg::eecu_word_type wdata,
  output      logic [3:0]              wstrb,
  input  wire logic                    bvalid,
  output      logic                    bready,
  input  wire logic [1:0]              bresp,
  output      logic                    arvalid,
  input  wire logic                    arready,
  output      logic [9:0]              araddr,
  input  wire logic                    rvalid,
  output      logic                    rready,
  input  wire eecu_pkg::eecu_word_type rdata,
  input  wire logic [1:0]              rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0;

  // Quiet bus at time zero
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
  end

  // Released lines show inverted data so stale values never match
  task automatic wr(input logic [9:0] a, input eecu_pkg::eecu_word_type v,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hF;
    bready <= !slow;
    n = 0;
    forever
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~v;
      end
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (n == 3)
        bready <= 1'b1;
    end
  endtask

  task automatic rd(input logic [9:0] a, output eecu_pkg::eecu_word_type v,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= !slow;
    n = 0;
    forever
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && rready)
      begin
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (n == 3)
        rready <= 1'b1;
    end
  endtask
endmodule

// ==== tb/eecu_tb_top.sv ====
// Purpose: self-checking bench for the enclave entry checker
// Assumes: bus tasks live in the software model
// Notes:   fault table walks the checks in priority order, 2 and 3 skipped, with a narrow-mode code limit row last
module eecu_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eecu_pkg::*;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic          awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready;
  logic [9:0]    awaddr, araddr;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp, r;
  eecu_word_type wdata, rdata, d;
  int            num_errors = 0;
  int            tests_run = 0;
  // Good wide-mode context, opt-out, trap flag set on entry
  eecu_word_type ctx [35] = '{32'h0203_6E47, 32'h1_2000, 32'h0, 32'h1_2000,
    32'h0, 32'h1, 32'h4000, 32'h0, 32'h10_0000, 32'h0, 32'h123, 32'h0,
    32'h1000, 32'h0, 32'h2000, 32'h0, 32'h3000, 32'h0, 32'h0, 32'h0, 32'hFFF,
    32'hFFF, 32'h0, 32'h0, 32'h3, 32'h7, 32'hAAAA_0000, 32'h0, 32'hBBBB_0000,
    32'h0, 32'h5678, 32'h0, 32'h2, 32'h11, 32'h22};
  int            rj [15] = '{0, 1, 4, 6, 7, 9, 10, 11, 15, 16, 17, 19, 21,
                             22, 23};
  eecu_word_type rv [15] = '{32'h10_0123, 32'h0, 32'h5678, 32'h2, 32'h4000,
    32'h10_2000, 32'h0, 32'h10_3000, 32'h7, 32'h3, 32'hAAAA_0000,
    32'hBBBB_0000, 32'h11, 32'h22, 32'h9000_0000};
  // One broken word per row, with the status it must raise
  int            fk [22] = '{0, 0, 0, 1, 0, 7, 0, 0, 0, 5, 0, 12, 16, 18, 0,
                             0, 0, 24, 18, 11, 15, 0};
  eecu_word_type fv [22] = '{32'h0203_6E85, 32'h0223_6E45, 32'h0203_6E55,
    32'h1_2004, 32'h0202_6E47, 32'h8000, 32'h0203_7E47, 32'h0201_6E47,
    32'h0207_6E47, 32'h2, 32'h0213_6E47, 32'h1800, 32'h3010, 32'h4,
    32'h0203_4E47, 32'h0203_6E45, 32'h0203_6A47, 32'hB, 32'h2, 32'h8000,
    32'h8000, 32'h0203_2E45};
  eecu_word_type fs [22] = '{32'h6, 32'h1_0006, 32'h4_0006, 32'h5_0006,
    32'h6_000A, 32'h7_0006, 32'h8_0006, 32'h9_000A, 32'hA_000A, 32'hB_000A,
    32'hC_000A, 32'hD_0006, 32'hE_0006, 32'hF_0006, 32'h10_0006,
    32'h11_0006, 32'h12_0006, 32'h13_0006, 32'h14_0006, 32'h15_0006,
    32'h16_0006, 32'h15_0006};

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  eecu_top dut
  (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
  );

  eecu_sw_model sw
  (
    .aclk(aclk), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
  );

  task test_done;
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input string n, input eecu_word_type e,
                     input eecu_word_type s);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Context word k sits k+1 words above the command
  task automatic put(input int k, input eecu_word_type v);
    sw.wr(10'(4 * (k + 1)), v, r);
  endtask

  task automatic res(input int j);
    sw.rd(10'(256 + 4 * j), d, r);
  endtask

  // Fire a command, then poll status until idle; status left in d
  task automatic go(input eecu_word_type c);
    sw.wr(10'h000, c, r);
    repeat (20)
    begin
      sw.rd(10'h0FC, d, r);
      if (d[0] === 1'b0)
        break;
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    sw.slow = 1'b1;
    sw.rd(10'h004, d, r);
    cmp("ctx0 reset", 32'h0, d);
    sw.rd(10'h0FC, d, r);
    cmp("status reset", 32'h1F_0000, d);
    sw.rd(10'h200, d, r);
    cmp("unmapped data", 32'h0, d);
    cmp("unmapped resp", 32'h2, {30'h0, r});
    sw.wr(10'h100, 32'hFFFF_FFFF, r);
    cmp("result write resp", 32'h2, {30'h0, r});
    sw.slow = 1'b0;
    for (int k = 0; k < 35; k++)
      put(k, ctx[k]);
    sw.rd(10'h06C, d, r);
    cmp("ctx26 readback", 32'hAAAA_0000, d);
    go(32'h1);
    cmp("entry status", 32'h1F_37D2, d);
    for (int i = 0; i < 15; i++)
    begin
      res(rj[i]);
      cmp("result", rv[i], d);
    end
    go(32'h2);
    cmp("exit status", 32'h800, d & 32'h810);
    put(18, 32'h3);
    go(32'h1);
    cmp("opt-in status", 32'h1F_2872, d & 32'h1F_2FFE);
    res(23);
    cmp("opt-in perf", 32'h0, d);
    go(32'h2);
    put(18, 32'h0);
    for (int i = 0; i < 22; i++)
    begin
      put(fk[i], fv[i]);
      go(32'h1);
      cmp("fault status", fs[i], d & 32'h1F_001E);
      if (fs[i][3])
      begin
        res(2);
        cmp("fault addr", 32'h1_2000, d);
      end
      put(fk[i], ctx[fk[i]]);
    end
    test_done;
  end

  // Hang guard, far beyond the several hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    test_done;
  end
endmodule

bind eecu_top eecu_top_sva u_sva
(
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .rresp(rresp)
);
